// ---- hdl/desp_channel.sv ----
// one channel's element sizing, address stepping and source packing
// Operation
// - Every address the channel forms is a byte address.
// - Size code 00b: byte accesses, any start address, step of 1.
// - Size code 01b: halfword accesses, start bit 0 clear, step of 2.
// - Size code 10b: word accesses, start bits 1:0 clear, step of 4.
// - Byte size with the peripheral port as source or destination is refused, so no bytes pack there.
// - With packing, four bytes from a word port form a 32-bit unit.
// - With packing, two halfwords from a word port form a 32-bit unit.
// - Both RAM ports and external memory have 32-bit buses.
// - The peripheral port has a 16-bit bus, which caps packing when it is the source.
// - Via the peripheral port no access starting in a protected window is made; only the start address is checked.
// - Bit 6 turns source packing on (1) or off (0).
// - Bits 5-2 pick the source port; codes above 0011b are reserved.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module desp_channel
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [3:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [15:0] REG_RDATA,
   output logic SRC_REQ,
   output desp_pkg::desp_req_t SRC_CMD,
   input wire logic SRC_ACK,
   input wire logic [31:0] SRC_RDATA,
   output logic XFER_VALID,
   output desp_pkg::desp_xfer_t XFER,
   output logic [3:0] XFER_PORT,
   input wire logic XFER_READY,
   output logic BUSY
);
   logic [15:0] port_params;
   logic [15:0] control;
   logic [23:0] src_start;
   logic [23:0] dst_start;
   logic [15:0] count_cfg;
   logic cfg_err;
   logic align_err;
   logic block_err;
   desp_pkg::desp_state_t state;
   desp_pkg::desp_state_t next_state;
   logic [23:0] src_addr;
   logic [23:0] dst_addr;
   logic [15:0] remaining;
   logic [1:0] size;
   logic [3:0] src_sel;
   logic [3:0] dst_sel;
   logic pack_en;
   logic [2:0] elem_bytes;
   logic [2:0] unit_bytes;
   logic [31:0] pack_data;
   logic [2:0] pack_fill;
   logic start;
   logic bad_cfg;
   logic bad_align;
   logic src_blocked;
   logic dst_blocked;
   logic take;
   logic unit_done;
   logic pushed;
   logic [15:0] rd_mux;

   // element size code to bytes per access
   function automatic logic [2:0] size_bytes(input logic [1:0] code);
      case (code)
         desp_pkg::SIZE_BYTE: size_bytes = 3'h1;
         desp_pkg::SIZE_HALF: size_bytes = 3'h2;
         default: size_bytes = 3'h4;
      endcase
   endfunction

   // internal bus width of each port
   function automatic logic [2:0] bus_bytes(input logic [3:0] sel);
      if (sel == desp_pkg::PORT_PERIPH)
         bus_bytes = desp_pkg::PERIPH_BUS_BYTES;
      else
         bus_bytes = desp_pkg::WIDE_BUS_BYTES;
   endfunction

   function automatic logic hits_protected(input logic [23:0] a);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < desp_pkg::NUM_BLOCKED; i++)
         if (a >= desp_pkg::BLOCKED_BASE[i] && a <= desp_pkg::BLOCKED_LAST[i])
            hit = 1'b1;
      hits_protected = hit;
   endfunction

   function automatic logic [23:0] step(input logic [23:0] a,
      input logic [1:0] mode, input logic [2:0] n);
      if (mode == desp_pkg::AMODE_POSTINC)
         step = a + 24'(n);
      else
         step = a;
   endfunction

   assign size = port_params[desp_pkg::SIZE_LSB +: 2];
   assign src_sel = port_params[desp_pkg::SRC_SEL_LSB +: 4];
   assign dst_sel = port_params[desp_pkg::DST_SEL_LSB +: 4];
   assign pack_en = port_params[desp_pkg::PACK_BIT];
   assign elem_bytes = size_bytes(size);

   // packing only where the bus is wider than the element
   always_comb
   begin
      if (pack_en && bus_bytes(src_sel) > elem_bytes)
         unit_bytes = bus_bytes(src_sel);
      else
         unit_bytes = elem_bytes;
   end

   // the reserved codes are caught here even though software should avoid them
   assign bad_cfg = (size == 2'b11)
      || (src_sel > desp_pkg::PORT_PERIPH)
      || (dst_sel > desp_pkg::PORT_PERIPH)
      || (size == desp_pkg::SIZE_BYTE
          && (src_sel == desp_pkg::PORT_PERIPH
              || dst_sel == desp_pkg::PORT_PERIPH));
   assign bad_align = ((size == desp_pkg::SIZE_HALF)
         && (src_start[0] || dst_start[0]))
      || ((size == desp_pkg::SIZE_WORD)
         && (src_start[1:0] != 2'b00 || dst_start[1:0] != 2'b00));

   assign start = REG_WR && REG_ADDR == desp_pkg::REG_CONTROL
      && REG_WDATA[desp_pkg::START_BIT] && state == desp_pkg::DESP_IDLE;

   // checked on every access, since stepping can walk into a window
   assign src_blocked = src_sel == desp_pkg::PORT_PERIPH
      && hits_protected(src_addr);
   assign dst_blocked = dst_sel == desp_pkg::PORT_PERIPH
      && hits_protected(dst_addr);

   assign SRC_REQ = state == desp_pkg::DESP_READ && !src_blocked;
   assign take = SRC_REQ && SRC_ACK;
   assign unit_done = take && (3'(pack_fill + elem_bytes) >= unit_bytes
      || remaining == 16'h0001);
   assign XFER_VALID = state == desp_pkg::DESP_PUSH && !dst_blocked;
   assign pushed = XFER_VALID && XFER_READY;
   assign BUSY = state != desp_pkg::DESP_IDLE;

   always_comb
   begin
      SRC_CMD.addr = src_addr;
      SRC_CMD.size = size;
      SRC_CMD.port = src_sel;
      XFER.data = pack_data;
      XFER.nbytes = pack_fill;
      XFER.addr = dst_addr;
      XFER_PORT = dst_sel;
   end

   always_comb
   begin
      next_state = state;
      case (state)
         desp_pkg::DESP_IDLE:
            if (start && !bad_cfg && !bad_align && count_cfg != 16'h0000)
               next_state = desp_pkg::DESP_READ;
         desp_pkg::DESP_READ:
            if (src_blocked)
               next_state = desp_pkg::DESP_IDLE;
            else if (unit_done)
               next_state = desp_pkg::DESP_PUSH;
         desp_pkg::DESP_PUSH:
            if (dst_blocked)
               next_state = desp_pkg::DESP_IDLE;
            else if (pushed)
               next_state = (remaining == 16'h0000) ? desp_pkg::DESP_IDLE
                  : desp_pkg::DESP_READ;
         default:
            next_state = desp_pkg::DESP_IDLE;
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
         state <= desp_pkg::DESP_IDLE;
      else
         state <= next_state;
   end

   // working addresses and element countdown
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         src_addr <= 24'h00_0000;
         dst_addr <= 24'h00_0000;
         remaining <= 16'h0000;
      end
      else if (state == desp_pkg::DESP_IDLE)
      begin
         src_addr <= src_start;
         dst_addr <= dst_start;
         remaining <= count_cfg;
      end
      else
      begin
         if (take)
         begin
            src_addr <= step(src_addr,
               control[desp_pkg::SRC_MODE_LSB +: 2], elem_bytes);
            remaining <= remaining - 16'h0001;
         end
         if (pushed)
            dst_addr <= step(dst_addr,
               control[desp_pkg::DST_MODE_LSB +: 2], pack_fill);
      end
   end

   desp_packer u_packer
   (
      .CLK(CLK),
      .SRST(SRST),
      .clear(pushed || state == desp_pkg::DESP_IDLE),
      .load(take),
      .elem(SRC_RDATA),
      .elem_bytes(elem_bytes),
      .packed_data(pack_data),
      .fill(pack_fill)
   );

   // software registers
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         port_params <= desp_pkg::PORT_PARAMS_RESET;
         control <= desp_pkg::CONTROL_RESET;
         src_start <= 24'h00_0000;
         dst_start <= 24'h00_0000;
         count_cfg <= 16'h0000;
      end
      else if (REG_WR && state == desp_pkg::DESP_IDLE)
      begin
         case (REG_ADDR)
            desp_pkg::REG_PORT_PARAMS:
               port_params <= REG_WDATA & desp_pkg::PORT_PARAMS_MASK;
            desp_pkg::REG_CONTROL:
               control <= {10'h000, REG_WDATA[5:2], 2'b00};
            desp_pkg::REG_SRC_LO: src_start[15:0] <= REG_WDATA;
            desp_pkg::REG_SRC_HI: src_start[23:16] <= REG_WDATA[7:0];
            desp_pkg::REG_DST_LO: dst_start[15:0] <= REG_WDATA;
            desp_pkg::REG_DST_HI: dst_start[23:16] <= REG_WDATA[7:0];
            desp_pkg::REG_COUNT: count_cfg <= REG_WDATA;
            default: ;
         endcase
      end
   end

   // sticky errors, write one to clear; a new error wins over the clear
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         cfg_err <= 1'b0;
         align_err <= 1'b0;
         block_err <= 1'b0;
      end
      else
      begin
         if (start && bad_cfg)
            cfg_err <= 1'b1;
         else if (REG_WR && REG_ADDR == desp_pkg::REG_STATUS
                  && REG_WDATA[desp_pkg::CFG_ERR_BIT])
            cfg_err <= 1'b0;
         if (start && bad_align)
            align_err <= 1'b1;
         else if (REG_WR && REG_ADDR == desp_pkg::REG_STATUS
                  && REG_WDATA[desp_pkg::ALIGN_ERR_BIT])
            align_err <= 1'b0;
         if ((state == desp_pkg::DESP_READ && src_blocked)
             || (state == desp_pkg::DESP_PUSH && dst_blocked))
            block_err <= 1'b1;
         else if (REG_WR && REG_ADDR == desp_pkg::REG_STATUS
                  && REG_WDATA[desp_pkg::BLOCK_ERR_BIT])
            block_err <= 1'b0;
      end
   end

   always_comb
   begin
      case (REG_ADDR)
         desp_pkg::REG_PORT_PARAMS: rd_mux = port_params;
         desp_pkg::REG_CONTROL: rd_mux = control;
         desp_pkg::REG_SRC_LO: rd_mux = src_start[15:0];
         desp_pkg::REG_SRC_HI: rd_mux = {8'h00, src_start[23:16]};
         desp_pkg::REG_DST_LO: rd_mux = dst_start[15:0];
         desp_pkg::REG_DST_HI: rd_mux = {8'h00, dst_start[23:16]};
         desp_pkg::REG_COUNT: rd_mux = remaining;
         desp_pkg::REG_STATUS:
            rd_mux = {12'h000, block_err, align_err, cfg_err, BUSY};
         default: rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
         REG_RDATA <= 16'h0000;
      else if (REG_RD)
         REG_RDATA <= rd_mux;
      else
         REG_RDATA <= 16'h0000;
   end
endmodule // desp_channel
`default_nettype wire

// ---- hdl/desp_pkg.sv ----
// constants and types shared by the element size and packing channel
package desp_pkg;

   localparam int ADDR_W = 24;
   localparam int REG_AW = 4;
   localparam int REG_DW = 16;

   // register indices
   localparam logic [3:0] REG_PORT_PARAMS = 4'h0;
   localparam logic [3:0] REG_CONTROL = 4'h1;
   localparam logic [3:0] REG_SRC_LO = 4'h2;
   localparam logic [3:0] REG_SRC_HI = 4'h3;
   localparam logic [3:0] REG_DST_LO = 4'h4;
   localparam logic [3:0] REG_DST_HI = 4'h5;
   localparam logic [3:0] REG_COUNT = 4'h6;
   localparam logic [3:0] REG_STATUS = 4'h7;

   // channel_port_parameters fields
   localparam int SIZE_LSB = 0;
   localparam int SRC_SEL_LSB = 2;
   localparam int PACK_BIT = 6;
   localparam int DST_SEL_LSB = 9;
   localparam logic [15:0] PORT_PARAMS_RESET = 16'h0000;
   localparam logic [15:0] PORT_PARAMS_MASK = 16'h1E7F;

   // control fields
   localparam int START_BIT = 0;
   localparam int SRC_MODE_LSB = 2;
   localparam int DST_MODE_LSB = 4;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;

   // status fields
   localparam int BUSY_BIT = 0;
   localparam int CFG_ERR_BIT = 1;
   localparam int ALIGN_ERR_BIT = 2;
   localparam int BLOCK_ERR_BIT = 3;

   localparam logic [1:0] SIZE_BYTE = 2'b00;
   localparam logic [1:0] SIZE_HALF = 2'b01;
   localparam logic [1:0] SIZE_WORD = 2'b10;

   localparam logic [3:0] PORT_SINGLE_RAM = 4'h0;
   localparam logic [3:0] PORT_DUAL_RAM = 4'h1;
   localparam logic [3:0] PORT_EXTMEM = 4'h2;
   localparam logic [3:0] PORT_PERIPH = 4'h3;

   localparam logic [1:0] AMODE_CONST = 2'b00;
   localparam logic [1:0] AMODE_POSTINC = 2'b01;

   localparam logic [2:0] WIDE_BUS_BYTES = 3'h4;
   localparam logic [2:0] PERIPH_BUS_BYTES = 3'h2;

   // peripheral windows the channel may not touch (byte addresses)
   localparam int NUM_BLOCKED = 7;
   localparam logic [6:0][23:0] BLOCKED_BASE = {
      24'h00_7000, 24'h00_6C00, 24'h00_6800, 24'h00_1000,
      24'h00_0800, 24'h00_0600, 24'h00_0400};
   localparam logic [6:0][23:0] BLOCKED_LAST = {
      24'h00_70FF, 24'h00_6CFF, 24'h00_68FF, 24'h00_10FF,
      24'h00_0BFF, 24'h00_06FF, 24'h00_04FF};

   typedef enum logic [1:0] {
      DESP_IDLE = 2'b00,
      DESP_READ = 2'b01,
      DESP_PUSH = 2'b10
   } desp_state_t;

   typedef struct packed {
      logic [31:0] data;
      logic [2:0] nbytes;
      logic [23:0] addr;
   } desp_xfer_t;

   typedef struct packed {
      logic [23:0] addr;
      logic [1:0] size;
      logic [3:0] port;
   } desp_req_t;

endpackage

// ---- hdl/desp_packer.sv ----
// packs successive elements low lane first into one bus-wide quantity
`timescale 1ns/100ps
`default_nettype none
module desp_packer
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic clear,
   input wire logic load,
   input wire logic [31:0] elem,
   input wire logic [2:0] elem_bytes,
   output logic [31:0] packed_data,
   output logic [2:0] fill
);
   logic [31:0] mask;
   logic [4:0] shift;

   always_comb
   begin
      shift = {fill[1:0], 3'b000};
      case (elem_bytes)
         3'h1: mask = 32'h0000_00FF;
         3'h2: mask = 32'h0000_FFFF;
         default: mask = 32'hFFFF_FFFF;
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (SRST || clear)
      begin
         packed_data <= 32'h0000_0000;
         fill <= 3'h0;
      end
      else if (load)
      begin
         packed_data <= packed_data | ((elem & mask) << shift);
         fill <= 3'(fill + elem_bytes);
      end
   end
endmodule // desp_packer
`default_nettype wire

// ---- dv/desp_src_model.sv ----
// source memory model answering the channel's element reads
`timescale 1ns/100ps
`default_nettype none
module desp_src_model
(
   input wire logic clk,
   input wire logic slow,
   input wire logic req,
   input wire desp_pkg::desp_req_t cmd,
   output logic ack,
   output logic [31:0] rdata
);
   logic tgl = 1'b0;
   function automatic logic [7:0] mb(input logic [23:0] a);
      return a[7:0] ^ {a[11:8], 4'h5};
   endfunction
   always @(posedge clk)
      tgl <= ~tgl;
   // slow mode answers every other cycle, as a busy memory would
   assign ack = req && (!slow || tgl);
   always_comb
   begin
      // little-endian lanes at the byte address
      rdata = {mb(cmd.addr + 24'h00_0003), mb(cmd.addr + 24'h00_0002),
         mb(cmd.addr + 24'h00_0001), mb(cmd.addr)};
      // peripheral bus has no upper lanes: they float
      if (cmd.port == desp_pkg::PORT_PERIPH)
         rdata[31:16] = {16{tgl}} ^ 16'h5A5A;
      if (!ack)
         rdata = ~rdata;
   end
endmodule // desp_src_model
`default_nettype wire

// ---- dv/desp_channel_asserts.sv ----
// port checker for the element size and packing channel
`timescale 1ns/100ps
`default_nettype none
module desp_channel_asserts
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [3:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [15:0] REG_RDATA,
   input wire logic SRC_REQ,
   input wire desp_pkg::desp_req_t SRC_CMD,
   input wire logic SRC_ACK,
   input wire logic XFER_VALID,
   input wire desp_pkg::desp_xfer_t XFER,
   input wire logic XFER_READY,
   input wire logic BUSY
);
   logic pack;
   logic [1:0] smode;
   logic blk;
   // shadow copies; writes while busy are dropped by the channel too
   always_ff @(posedge CLK)
   begin
      if (SRST)
         pack <= 1'b0;
      else if (REG_WR && !BUSY && REG_ADDR == 4'h0)
         pack <= REG_WDATA[desp_pkg::PACK_BIT];
   end
   always_ff @(posedge CLK)
   begin
      if (SRST)
         smode <= 2'b00;
      else if (REG_WR && !BUSY && REG_ADDR == 4'h1)
         smode <= REG_WDATA[3:2];
   end
   always_comb
   begin
      blk = 1'b0;
      for (int i = 0; i < desp_pkg::NUM_BLOCKED; i++)
         if (SRC_CMD.addr >= desp_pkg::BLOCKED_BASE[i] &&
            SRC_CMD.addr <= desp_pkg::BLOCKED_LAST[i])
            blk = 1'b1;
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   sequence s_take;
      SRC_REQ && SRC_ACK;
   endsequence
   sequence s_take_more;
      s_take ##1 SRC_REQ;
   endsequence
   property p_src_step;
      s_take_more |-> SRC_CMD.addr == $past(SRC_CMD.addr) +
         (smode == 2'b01 ? (24'h00_0001 << $past(SRC_CMD.size))
         : 24'h00_0000);
   endproperty
   a_src_step: assert property (p_src_step)
      else $error("source address step wrong");
   property p_align;
      SRC_REQ |-> !(SRC_CMD.size == 2'b01 && SRC_CMD.addr[0]) &&
         !(SRC_CMD.size == 2'b10 && SRC_CMD.addr[1:0] != 2'b00);
   endproperty
   a_align: assert property (p_align)
      else $error("misaligned source access");
   property p_cfg;
      SRC_REQ |-> SRC_CMD.size != 2'b11 && SRC_CMD.port <= 4'h3 &&
         !(SRC_CMD.size == 2'b00 && SRC_CMD.port == 4'h3);
   endproperty
   a_cfg: assert property (p_cfg)
      else $error("access with refused configuration");
   property p_protect;
      SRC_REQ && SRC_CMD.port == 4'h3 |-> !blk;
   endproperty
   a_protect: assert property (p_protect)
      else $error("protected window reached");
   property p_unit;
      XFER_VALID |-> XFER.nbytes != 3'h0 &&
         XFER.nbytes <= (SRC_CMD.port == 4'h3 ? 3'h2 : 3'h4);
   endproperty
   a_unit: assert property (p_unit)
      else $error("unit wider than source bus");
   property p_nopack;
      XFER_VALID && !pack |-> XFER.nbytes == (3'h1 << SRC_CMD.size);
   endproperty
   a_nopack: assert property (p_nopack)
      else $error("unpacked unit not one element");
   property p_hold;
      XFER_VALID && !XFER_READY |=> XFER_VALID && $stable(XFER);
   endproperty
   a_hold: assert property (p_hold)
      else $error("unit changed before taken");
   property p_rdata;
      !$past(REG_RD) |-> REG_RDATA == 16'h0000;
   endproperty
   a_rdata: assert property (p_rdata)
      else $error("read data outside its cycle");
   property p_busy;
      SRC_REQ || XFER_VALID |-> BUSY;
   endproperty
   a_busy: assert property (p_busy)
      else $error("traffic while idle");
endmodule // desp_channel_asserts
bind desp_channel desp_channel_asserts i_chk (.CLK(CLK), .SRST(SRST),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
   .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SRC_REQ(SRC_REQ),
   .SRC_CMD(SRC_CMD), .SRC_ACK(SRC_ACK), .XFER_VALID(XFER_VALID),
   .XFER(XFER), .XFER_READY(XFER_READY), .BUSY(BUSY));
`default_nettype wire

// ---- dv/tb_desp_channel.sv ----
// self-checking bench for the element size and packing channel
`timescale 1ns/100ps
`default_nettype none
module tb_desp_channel;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] ra = 4'h0;
   logic [15:0] wd = 16'h0000;
   logic [15:0] rdat;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic xr = 1'b0;
   logic slow = 1'b0;
   logic req, ack, xv, busy;
   logic [31:0] sdat;
   logic [3:0] xp;
   desp_pkg::desp_req_t cmd;
   desp_pkg::desp_xfer_t xf;
   int n_mismatch = 0;
   int cmp_count = 0;
   always #10 clk = ~clk;
   desp_channel i_dut (.CLK(clk), .SRST(srst), .REG_ADDR(ra),
      .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat),
      .SRC_REQ(req), .SRC_CMD(cmd), .SRC_ACK(ack), .SRC_RDATA(sdat),
      .XFER_VALID(xv), .XFER(xf), .XFER_PORT(xp), .XFER_READY(xr),
      .BUSY(busy));
   desp_src_model i_src (.clk(clk), .slow(slow), .req(req), .cmd(cmd),
      .ack(ack), .rdata(sdat));
   function automatic logic [7:0] mb(input logic [23:0] a);
      return a[7:0] ^ {a[11:8], 4'h5};
   endfunction
   task summarize;
      $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      ra <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      ra <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdat;
   endtask
   // one block; expected units follow from size, bus width and packing
   task run(input logic [15:0] cfg, input logic [15:0] ctl,
      input logic [15:0] sa, input logic [15:0] da, input int cnt);
      logic [23:0] s;
      logic [23:0] d;
      logic [2:0] eb, ub, nb;
      logic [31:0] e;
      int left, to;
      eb = 3'h1 << cfg[1:0];
      ub = (cfg[5:2] == 4'h3) ? 3'h2 : 3'h4;
      if (!cfg[6] || ub < eb)
         ub = eb;
      s = {8'h00, sa};
      d = {8'h00, da};
      left = cnt * eb;
      wr_reg(4'h0, cfg);
      wr_reg(4'h2, sa);
      wr_reg(4'h4, da);
      wr_reg(4'h6, 16'(cnt));
      wr_reg(4'h1, ctl);
      while (left > 0)
      begin
         to = 0;
         while (xv !== 1'b1 && to < 50)
         begin
            @(posedge clk);
            #1 to++;
         end
         chk(xv, 1'b1);
         nb = (left < ub) ? 3'(left) : ub;
         e = 32'h0000_0000;
         for (int i = 0; i < nb; i++)
         begin
            e[8*i +: 8] = mb(s + 24'(i % eb));
            if (ctl[3:2] == 2'b01 && i % eb == eb - 1)
               s = s + 24'(eb);
         end
         chk(xf.data & (32'hFFFF_FFFF >> (32 - 8 * nb)), e);
         chk(xf.nbytes, nb);
         chk(xf.addr, d);
         chk(xp, cfg[12:9]);
         if (ctl[5:4] == 2'b01)
            d = d + 24'(nb);
         left = left - nb;
         if (slow)
            repeat (3) @(posedge clk);
         @(posedge clk);
         xr <= 1'b1;
         @(posedge clk);
         xr <= 1'b0;
         #1;
      end
      chk(busy, 1'b0);
   endtask
   task refuse(input logic [15:0] cfg, input logic [15:0] sa,
      input logic [15:0] exp);
      logic [15:0] v;
      wr_reg(4'h0, cfg);
      wr_reg(4'h2, sa);
      wr_reg(4'h1, 16'h0015);
      repeat (3) @(posedge clk);
      rd_reg(4'h7, v);
      chk(v, exp);
      wr_reg(4'h7, 16'h000F);
   endtask
   task t_reset;
      logic [15:0] v;
      rd_reg(4'h0, v);
      chk(v, desp_pkg::PORT_PARAMS_RESET);
      rd_reg(4'h8, v);
      chk(v, 16'h0000);
      wr_reg(4'h0, 16'hFFFF);
      rd_reg(4'h0, v);
      chk(v, desp_pkg::PORT_PARAMS_MASK);
      wr_reg(4'h3, 16'h01FF);
      rd_reg(4'h3, v);
      chk(v, 16'h00FF);
      wr_reg(4'h3, 16'h0000);
   endtask
   task t_byte_pack;
      run(16'h0040, 16'h0015, 16'h0103, 16'h0200, 5);
   endtask
   task t_half_pack;
      slow = 1'b1;
      run(16'h0245, 16'h0015, 16'h0302, 16'h0400, 3);
      slow = 1'b0;
   endtask
   task t_periph;
      run(16'h044D, 16'h0015, 16'h2000, 16'h0500, 2);
   endtask
   task t_word;
      run(16'h004A, 16'h0005, 16'h0104, 16'h0600, 2);
   endtask
   task t_nopack;
      run(16'h0000, 16'h0011, 16'h0107, 16'h0300, 3);
   endtask
   task t_refuse;
      refuse(16'h0003, 16'h0100, 16'h0002);
      refuse(16'h000C, 16'h0100, 16'h0002);
      refuse(16'h0010, 16'h0100, 16'h0002);
      refuse(16'h0001, 16'h0101, 16'h0004);
      refuse(16'h0002, 16'h0102, 16'h0004);
      refuse(16'h000D, 16'h0600, 16'h0008);
      // destination side: peripheral port aimed into a protected window
      wr_reg(4'h4, 16'h0400);
      refuse(16'h0601, 16'h0100, 16'h0008);
   endtask
   initial
   begin
      #200000;
      n_mismatch++;
      summarize();
   end
   initial
   begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_byte_pack();
      t_half_pack();
      t_periph();
      t_word();
      t_nopack();
      t_refuse();
      summarize();
   end
endmodule // tb_desp_channel
`default_nettype wire
